// File: rtl/ptph_pkg.sv
// Shared constants and carrier types for the pixel thread payload header block
package ptph_pkg;

    // Payload phases, in delivery order
    localparam int NPH = 8;
    localparam int PH_HDR0 = 0;
    localparam int PH_HDR1 = 1;
    localparam int PH_BARY = 2;
    localparam int PH_DEPTH = 3;
    localparam int PH_WCOORD = 4;
    localparam int PH_POSOFF = 5;
    localparam int PH_CONST = 6;
    localparam int PH_SETUP = 7;
    localparam int PH_SZ_W = 4;
    localparam int REGN_W = 8;

    // Register byte addresses
    localparam logic [15:0] OFF_CTRL = 16'h0000;
    localparam logic [15:0] OFF_SNAP = 16'h0004;
    localparam logic [15:0] OFF_SIZES = 16'h0008;
    localparam logic [15:0] OFF_GAPS = 16'h000c;
    localparam logic [15:0] OFF_STAT = 16'h0010;
    localparam logic [15:0] OFF_LAY_LO = 16'h0014;
    localparam logic [15:0] OFF_LAY_HI = 16'h0018;
    localparam logic [15:0] OFF_SCRATCH = 16'h21d0;

    // Control fields
    localparam int CTRL_SNAP_EN = 0;
    localparam int CTRL_SNAP_SRC = 1;
    localparam int CTRL_PH_LSB = 8;
    localparam int SCR_BIG_BIT = 3;
    localparam int STAT_ERR_BIT = 31;
    localparam int GAP_SETUP_LSB = 8;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;
    localparam logic [31:0] SIZES_RST = 32'h1111_1111;
    localparam logic [31:0] GAPS_RST = 32'h0000_0000;
    localparam logic [31:0] SCR_RST = 32'h0000_0000;

    // Header field positions
    localparam int SNAP_BIT = 31;
    localparam int CNT_W = 24;
    localparam int SCR_PTR_LSB = 10;
    localparam int COLOR_LSB = 8;
    localparam int TBL_LSB = 5;
    localparam int SIZE_W = 4;

    // Scratch size decoding
    localparam logic [3:0] SIZE_BIG_CODE = 4'hb;
    localparam logic [8:0] SCR_KB_BIG = 9'h100;
    localparam int BIG_ALIGN_LSB = 23;

    // Dispatch request from the window_masker_stage
    typedef struct packed {
        logic [CNT_W-1:0] prim_cnt;
        logic [31-SCR_PTR_LSB:0] scratch_ptr;
        logic [1:0] color;
        logic [7:0] thread_resource_tag;
        logic [31-TBL_LSB:0] bind_ptr;
        logic [31-TBL_LSB:0] samp_ptr;
        logic [SIZE_W-1:0] size_code;
    } ptph_req_t;

    // Header dwords seven down to three
    typedef struct packed {
        logic [31:0] dw7;
        logic [31:0] dw6;
        logic [31:0] dw5;
        logic [31:0] dw4;
        logic [31:0] dw3;
    } ptph_hdr_t;

endpackage

// File: rtl/ptph_hdr_pack.sv
// Packs dispatch fields into header dwords seven down to three
`timescale 1ns/1ps
`default_nettype none
module ptph_hdr_pack (
    // Request fields
    input wire ptph_pkg::ptph_req_t req,
    input wire logic [ptph_pkg::CNT_W-1:0] thread_cnt,
    input wire logic snap,
    // Packed header
    output ptph_pkg::ptph_hdr_t hdr
);
    // Reserved spans are tied to zero
    always_comb
    begin
        hdr = '0; // [R15]
        hdr.dw7[ptph_pkg::SNAP_BIT] = snap; // [R04]
        hdr.dw7[ptph_pkg::CNT_W-1:0] = req.prim_cnt; // [R05]
        hdr.dw6[ptph_pkg::CNT_W-1:0] = thread_cnt; // [R06]
        hdr.dw5[31:ptph_pkg::SCR_PTR_LSB] = req.scratch_ptr; // [R07]
        hdr.dw5[ptph_pkg::COLOR_LSB+1:ptph_pkg::COLOR_LSB] = req.color; // [R08]
        hdr.dw5[7:0] = req.thread_resource_tag; // [R09]
        hdr.dw4[31:ptph_pkg::TBL_LSB] = req.bind_ptr; // [R10]
        hdr.dw3[31:ptph_pkg::TBL_LSB] = req.samp_ptr; // [R11]
        // Code passes verbatim; decoding never alters it
        hdr.dw3[ptph_pkg::SIZE_W-1:0] = req.size_code; // [R12] [R14]
    end
endmodule // ptph_hdr_pack
`default_nettype wire

// File: rtl/ptph_layout.sv
// Computes packed register numbers for each enabled payload phase
`timescale 1ns/1ps
`default_nettype none
module ptph_layout (
    // Configuration
    input wire logic [ptph_pkg::NPH-1:0] ph_en,
    input wire logic [ptph_pkg::NPH*ptph_pkg::PH_SZ_W-1:0] ph_size,
    input wire logic [ptph_pkg::REGN_W-1:0] gap_const,
    input wire logic [ptph_pkg::REGN_W-1:0] gap_setup,
    // Layout
    output logic [ptph_pkg::NPH*ptph_pkg::REGN_W-1:0] ph_start,
    output logic [ptph_pkg::REGN_W-1:0] total_len
);
    // Walk phases in order, skipped phases take no registers
    always_comb
    begin
        logic [ptph_pkg::REGN_W-1:0] nxt;
        nxt = '0; // [R02]
        ph_start = '0;
        for (int i = 0; i < ptph_pkg::NPH; i++)
        begin
            if (ph_en[i]) // [R01]
            begin
                // Only these two phases may start past the packed point
                if (i == ptph_pkg::PH_CONST && nxt < gap_const)
                    nxt = gap_const; // [R03]
                if (i == ptph_pkg::PH_SETUP && nxt < gap_setup)
                    nxt = gap_setup; // [R03]
                ph_start[i*ptph_pkg::REGN_W +: ptph_pkg::REGN_W] = nxt;
                nxt = nxt + ptph_pkg::REGN_W'(ph_size[i*ptph_pkg::PH_SZ_W +: ptph_pkg::PH_SZ_W]);
            end
        end
        total_len = nxt;
    end
endmodule // ptph_layout
`default_nettype wire

// File: rtl/ptph_core.sv
// Pixel thread payload header assembly: registers, dispatch and layout
//
// Summary of operation
// [R01] Phases in fixed order; disabled phases omitted
// [R02] Registers from zero; later phases pack down
// [R03] Gaps only before constant and setup phases
// [R04] Dword seven top bit flags debug match
// [R05] Dword seven low bits: primitive thread count
// [R06] Dword six: thread counter, plus one per thread
// [R07] Dword five upper bits: 1KB scratch pointer
// [R08] Dword five bits nine, eight: colour code
// [R09] Dword five low byte: resource tag
// [R10] Dword four: 32-byte binding table pointer
// [R11] Dword three: 32-byte sampler state pointer
// [R12] Dword three low nibble: scratch size code
// [R13] Early stepping: code eleven means 256KB
// [R14] Size code forwarded unchanged, informational only
// [R15] Reserved header bits driven to zero
`timescale 1ns/1ps
`default_nettype none
module ptph_core #(
    parameter int CNT_W = ptph_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Dispatch request side
    input wire logic disp_valid,
    output logic disp_ready,
    input wire ptph_pkg::ptph_req_t disp_req,
    // Thread payload side
    output logic thr_valid,
    input wire logic thr_ready,
    output ptph_pkg::ptph_hdr_t thr_hdr,
    output logic [ptph_pkg::NPH-1:0] thr_ph_en,
    output logic [ptph_pkg::NPH*ptph_pkg::REGN_W-1:0] thr_ph_start,
    output logic [ptph_pkg::REGN_W-1:0] thr_len,
    output logic [8:0] thr_scratch_kb
);

    // Codes above eleven are undefined;
    // they decode linearly, since the
    // header keeps the raw code anyway
    // A function keeps the decode in one place
    // Scratch size in KB for a code, with the early-stepping exception
    function automatic logic [8:0] scratch_kb(
        input logic [3:0] code,
        input logic big_mode
    );
        if (big_mode && code == ptph_pkg::SIZE_BIG_CODE)
            scratch_kb = ptph_pkg::SCR_KB_BIG; // [R13]
        else
            scratch_kb = {5'h00, code} + 9'h001; // [R12]
    endfunction

    // Kept apart so the alignment check
    // does not hang on size reporting
    // True when code and mode select the oversize scratch
    function automatic logic is_big(
        input logic [3:0] code,
        input logic big_mode
    );
        is_big = big_mode && (code == ptph_pkg::SIZE_BIG_CODE);
    endfunction

    // Register map notes:
    // full 32-bit words, written whole
    // unmapped writes are dropped
    // reads come from a flip-flop
    // the bus never waits
    // reset values live in the package, except snapshot match and status, which reset to zero
    // sticky error clears by writing one
    // Software-visible registers
    logic [31:0] ctrl_q; // Snapshot and phase enables
    logic [31:0] snap_q; // Debug match value
    logic [31:0] sizes_q; // Per-phase register counts
    logic [31:0] gaps_q; // Earliest starts for gap phases
    logic [31:0] scr_q; // Early stepping scratch control
    logic err_q; // Sticky misaligned big scratch
    logic [31:0] rdata_q; // Read data, one cycle late

    // One payload deep: a second request
    // waits, so counter, header and layout
    // always describe the same thread
    // Held until the consumer's ready
    // Dispatch state
    logic [CNT_W-1:0] thr_cnt_q; // Threads dispatched so far
    logic valid_q; // Payload held for the consumer
    ptph_pkg::ptph_hdr_t hdr_q; // Registered header
    logic [ptph_pkg::NPH-1:0] ph_en_q; // Phases of held payload
    logic [ptph_pkg::NPH*ptph_pkg::REGN_W-1:0] start_q; // Starts
    logic [ptph_pkg::REGN_W-1:0] len_q; // Payload length
    logic [8:0] kb_q; // Decoded scratch size

    // Derived from live request and
    // registers; no state of their own
    // Combinational helpers
    logic fire; // Request taken this cycle
    logic snap_hit; // Debug criteria matched
    logic big_mode; // Oversize scratch enabled
    logic misalign; // Big scratch base not 8MB aligned
    logic [ptph_pkg::NPH-1:0] ph_en; // Effective phase enables
    logic [CNT_W-1:0] snap_cmp; // Value compared for snapshot
    ptph_pkg::ptph_hdr_t hdr_c; // Header being built
    logic [ptph_pkg::NPH*ptph_pkg::REGN_W-1:0] start_c; // Layout
    logic [ptph_pkg::REGN_W-1:0] len_c; // Layout length
    logic wr_ctrl; // Write strobes per register
    logic wr_snap;
    logic wr_sizes;
    logic wr_gaps;
    logic wr_stat;
    logic wr_scr;

    // Full address compare: a partial
    // decode could let a stray write
    // flip the oversize scratch mode
    // Writes take effect at the next edge
    // Register write decode
    assign wr_ctrl = reg_wr && reg_addr == ptph_pkg::OFF_CTRL;
    assign wr_snap = reg_wr && reg_addr == ptph_pkg::OFF_SNAP;
    assign wr_sizes = reg_wr && reg_addr == ptph_pkg::OFF_SIZES;
    assign wr_gaps = reg_wr && reg_addr == ptph_pkg::OFF_GAPS;
    assign wr_stat = reg_wr && reg_addr == ptph_pkg::OFF_STAT;
    assign wr_scr = reg_wr && reg_addr == ptph_pkg::OFF_SCRATCH;

    // Ready is combinational so a drained
    // slot refills in the same cycle
    // Path from consumer ready is short
    // Handshake: one holding stage, refilled when drained
    assign disp_ready = !valid_q || thr_ready;
    assign fire = disp_valid && disp_ready;

    // Phase zero cannot be switched off;
    // the thread needs its header
    // The header phase is always present
    always_comb
    begin
        ph_en = ctrl_q[ptph_pkg::CTRL_PH_LSB +: ptph_pkg::NPH]; // [R01]
        ph_en[ptph_pkg::PH_HDR0] = 1'b1;
    end

    // Thread count is the one this thread
    // carries, taken before the step
    // Debug capture compares either the primitive or thread count
    assign snap_cmp = ctrl_q[ptph_pkg::CTRL_SNAP_SRC] ? disp_req.prim_cnt : thr_cnt_q;
    assign snap_hit = ctrl_q[ptph_pkg::CTRL_SNAP_EN] && snap_cmp == snap_q[CNT_W-1:0]; // [R04]

    // Oversize scratch is an early silicon
    // fix-up; software also aligns the base
    // Oversize scratch checks
    assign big_mode = scr_q[ptph_pkg::SCR_BIG_BIT];
    // Base must clear bits below 8MB; software owns this, we only flag it
    assign misalign = is_big(disp_req.size_code, big_mode)
        && disp_req.scratch_ptr[ptph_pkg::BIG_ALIGN_LSB-ptph_pkg::SCR_PTR_LSB-1:0] != '0; // [R13]

    // Bit layout kept in one small module
    // Header field packing
    ptph_hdr_pack u_pack (
        .req (disp_req),
        .thread_cnt (thr_cnt_q),
        .snap (snap_hit),
        .hdr (hdr_c)
    );

    // Layout follows the registers every
    // cycle but is captured only on a
    // taken request, so a write between
    // threads never tears a payload
    // Payload phase layout
    ptph_layout u_layout (
        .ph_en (ph_en),
        .ph_size (sizes_q),
        .gap_const (gaps_q[ptph_pkg::REGN_W-1:0]),
        .gap_setup (gaps_q[ptph_pkg::GAP_SETUP_LSB +: ptph_pkg::REGN_W]),
        .ph_start (start_c),
        .total_len (len_c)
    );

    // One process per register, all with
    // the same reset; full-word write except scratch, which keeps bit three only, and status, where a one in bit 31 clears the error
    // Control register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ctrl_q <= ptph_pkg::CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= reg_wdata;
    end

    // Upper bits are kept for read-back
    // Snapshot match value
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            snap_q <= '0;
        else if (wr_snap)
            snap_q <= reg_wdata;
    end

    // Four bits per phase, phase zero low
    // Phase sizes; a change applies to the next dispatch
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            sizes_q <= ptph_pkg::SIZES_RST;
        else if (wr_sizes)
            sizes_q <= reg_wdata;
    end

    // A gap below the packed point has
    // no effect on the start
    // Values above 255 cannot be set
    // Gap starts for the constant and setup phases
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            gaps_q <= ptph_pkg::GAPS_RST;
        else if (wr_gaps)
            gaps_q <= reg_wdata;
    end

    // Other bits are not ours; storing
    // them would suggest a meaning
    // Only bit three is kept
    // Early stepping scratch control, only the mode bit is kept
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            scr_q <= ptph_pkg::SCR_RST;
        else if (wr_scr)
            scr_q <= reg_wdata & (32'h0000_0001 << ptph_pkg::SCR_BIG_BIT);
    end

    // Event and clear in one cycle: the
    // flag stays, so no evidence is lost
    // Sticky misalignment flag, set wins over write-one-to-clear
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            err_q <= 1'b0;
        else if (fire && misalign)
            err_q <= 1'b1; // [R13]
        else if (wr_stat && reg_wdata[ptph_pkg::STAT_ERR_BIT])
            err_q <= 1'b0;
    end

    // Wraps at the top of its width, as
    // the header field does
    // Stepped only on a taken request
    // Thread counter, one step per dispatched thread
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            thr_cnt_q <= '0;
        else if (fire)
            thr_cnt_q <= thr_cnt_q + 1'b1; // [R06]
    end

    // A request in the draining cycle keeps
    // valid high: full-rate back to back
    // without a bubble
    // Holding stage valid
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            valid_q <= 1'b0;
        else if (fire)
            valid_q <= 1'b1;
        else if (thr_ready)
            valid_q <= 1'b0;
    end

    // Reset clears the held payload, so
    // nothing stale shows before thread one
    // Captured fields stay until replaced
    // Holding stage data, captured only on a taken request
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            hdr_q <= '0;
            ph_en_q <= '0;
            start_q <= '0;
            len_q <= '0;
            kb_q <= '0;
        end
        else if (fire)
        begin
            hdr_q <= hdr_c; // [R14]
            ph_en_q <= ph_en; // [R01]
            start_q <= start_c; // [R02]
            len_q <= len_c;
            kb_q <= scratch_kb(disp_req.size_code, big_mode); // [R13]
        end
    end

    // Zero outside the answer cycle, so
    // slaves can be ORed onto one bus
    // A read that matches nothing gives zero
    // Read data mux, registered so data stand the cycle after
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdata_q <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                ptph_pkg::OFF_CTRL: rdata_q <= ctrl_q;
                ptph_pkg::OFF_SNAP: rdata_q <= snap_q;
                ptph_pkg::OFF_SIZES: rdata_q <= sizes_q;
                ptph_pkg::OFF_GAPS: rdata_q <= gaps_q;
                // Live counter and sticky error;
                // the count runs on during the read
                ptph_pkg::OFF_STAT: rdata_q <= {err_q, 31'(thr_cnt_q)};
                // Layout of the last taken payload
                ptph_pkg::OFF_LAY_LO: rdata_q <= start_q[31:0];
                ptph_pkg::OFF_LAY_HI: rdata_q <= start_q[63:32];
                ptph_pkg::OFF_SCRATCH: rdata_q <= scr_q;
                // Unmapped addresses read as zero
                default: rdata_q <= '0;
            endcase
        end
        else
            rdata_q <= '0;
    end

    // Data outputs come from flip-flops;
    // only ready is combinational
    // Outputs
    assign reg_rdata = rdata_q;
    assign thr_valid = valid_q;
    assign thr_hdr = hdr_q;
    assign thr_ph_en = ph_en_q;
    assign thr_ph_start = start_q;
    assign thr_len = len_q;
    assign thr_scratch_kb = kb_q;


    // Limits: one holding stage; gap
    // values are not checked against the
    // size of the register file; the
    // decoded size never feeds the header
endmodule // ptph_core
`default_nettype wire

// File: tb/ptph_core_chk.sv
// Port assertions for the payload header block
`timescale 1ns/1ps
`default_nettype none
module ptph_core_chk (
    // Clock, reset and read port
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Dispatch and payload sides
    input wire logic disp_valid,
    input wire logic disp_ready,
    input wire ptph_pkg::ptph_req_t disp_req,
    input wire logic thr_valid,
    input wire logic thr_ready,
    input wire ptph_pkg::ptph_hdr_t thr_hdr,
    input wire logic [ptph_pkg::NPH-1:0] thr_ph_en,
    input wire logic [ptph_pkg::NPH*ptph_pkg::REGN_W-1:0] thr_ph_start,
    input wire logic [8:0] thr_scratch_kb
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic fire; // Request taken at this edge
    logic [23:0] fires_q; // Threads taken since reset
    assign fire = disp_valid && disp_ready;
    // Own thread count, so a stuck design counter shows up
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fires_q <= 24'h000000;
        else if (fire)
            fires_q <= fires_q + 24'h000001;
    end
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");
    payload_hold_a: assert property (thr_valid && !thr_ready |-> !disp_ready ##1 thr_valid && $stable(thr_hdr))
        else $error("held payload lost or changed");
    fire_out_a: assert property (fire |=> thr_valid)
        else $error("no payload after request");
    thread_count_a: assert property (fire |=> thr_hdr.dw6 == {8'h00, $past(fires_q)})
        else $error("thread counter wrong");
    prim_count_a: assert property (fire |=> thr_hdr.dw7[30:0] == {7'h00, $past(disp_req.prim_cnt)})
        else $error("primitive count wrong");
    dword_five_a: assert property (fire |=> thr_hdr.dw5[31:10] == $past(disp_req.scratch_ptr) && thr_hdr.dw5[9:8] == $past(disp_req.color) && thr_hdr.dw5[7:0] == $past(disp_req.thread_resource_tag))
        else $error("dword five wrong");
    table_ptrs_a: assert property (fire |=> thr_hdr.dw4 == {$past(disp_req.bind_ptr), 5'h00} && thr_hdr.dw3 == {$past(disp_req.samp_ptr), 1'b0, $past(disp_req.size_code)})
        else $error("table pointers or size code wrong");
    small_size_a: assert property (fire && disp_req.size_code != 4'hb |=> thr_scratch_kb == 9'h001 + $past(disp_req.size_code))
        else $error("scratch size decode wrong");
    first_phase_a: assert property (thr_valid |-> thr_ph_en[0] && thr_ph_start[7:0] == 8'h00)
        else $error("header phase not at register zero");
endmodule // ptph_core_chk
bind ptph_core ptph_core_chk u_chk (.clk_sys(clk_sys), .reset(reset), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .disp_valid(disp_valid), .disp_ready(disp_ready),
    .disp_req(disp_req), .thr_valid(thr_valid), .thr_ready(thr_ready), .thr_hdr(thr_hdr),
    .thr_ph_en(thr_ph_en), .thr_ph_start(thr_ph_start), .thr_scratch_kb(thr_scratch_kb));
`default_nettype wire

// File: tb/ptph_shader_model.sv
// Model of the shader units that take dispatched payloads
`timescale 1ns/1ps
`default_nettype none
module ptph_shader_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Pacing and handshake
    input wire logic slow,
    output logic thr_ready
);
    // Ready every cycle, or one cycle in four at random when slow
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            thr_ready <= 1'b0;
        else
            thr_ready <= !slow || ($urandom_range(3) == 0);
    end
endmodule // ptph_shader_model
`default_nettype wire

// File: tb/ptph_core_test.sv
// Self-checking bench for the payload header block
`timescale 1ns/1ps
`default_nettype none
module ptph_core_test;
    logic clk_sys, reset, reg_wr, reg_rd, disp_valid, disp_ready, thr_valid, thr_ready, slow, big;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ctrl, sizes, gaps, snapv;
    logic [127:0] rv; // Raw random request bits
    ptph_pkg::ptph_req_t disp_req, rq;
    ptph_pkg::ptph_hdr_t thr_hdr;
    logic [7:0] thr_ph_en, thr_len;
    logic [63:0] thr_ph_start;
    logic [8:0] thr_scratch_kb;
    int n_fail, checked, tcount, cyc = 0;
    ptph_pkg::ptph_hdr_t hq[$]; // Expected headers, in dispatch order
    logic [88:0] lq[$]; // Expected layout and scratch size
    ptph_core uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disp_valid(disp_valid),
        .disp_ready(disp_ready), .disp_req(disp_req), .thr_valid(thr_valid),
        .thr_ready(thr_ready), .thr_hdr(thr_hdr), .thr_ph_en(thr_ph_en),
        .thr_ph_start(thr_ph_start), .thr_len(thr_len), .thr_scratch_kb(thr_scratch_kb));
    ptph_shader_model shd (.clk_sys(clk_sys), .reset(reset), .slow(slow), .thr_ready(thr_ready));
    // Free-running core clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Packed layout; gaps only ahead of the constant and setup phases
    function automatic logic [88:0] exp_lay(logic [3:0] code);
        logic [7:0] en, pos;
        logic [63:0] st;
        en = ctrl[15:8] | 8'h01;
        pos = 8'h00;
        st = 64'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (en[i])
            begin
                if (i == ptph_pkg::PH_CONST && gaps[7:0] > pos)
                    pos = gaps[7:0];
                if (i == ptph_pkg::PH_SETUP && gaps[15:8] > pos)
                    pos = gaps[15:8];
                st[8*i +: 8] = pos;
                pos = pos + {4'h0, sizes[4*i +: 4]};
            end
        end
        return {en, st, pos, (big && code == 4'hb) ? 9'h100 : 9'h001 + code};
    endfunction
    // Header dwords seven to three for one thread
    function automatic ptph_pkg::ptph_hdr_t exp_hdr(ptph_pkg::ptph_req_t r, logic [23:0] n);
        logic hit;
        hit = ctrl[0] && ((ctrl[1] ? r.prim_cnt : n) == snapv[23:0]);
        return {hit, 7'h00, r.prim_cnt, 8'h00, n, r.scratch_ptr, r.color, r.thread_resource_tag,
            r.bind_ptr, 5'h00, r.samp_ptr, 1'b0, r.size_code};
    endfunction
    // Mismatch report
    task automatic bad(logic [159:0] g, logic [159:0] e);
        n_fail++;
        $display("BAD %0t got %h exp %h", $time, g, e);
    endtask
    task automatic cmp_reg(logic [31:0] g, logic [31:0] e);
        checked++;
        if (g !== e)
            bad({128'h0, g}, {128'h0, e});
    endtask
    task automatic cmp_hdr(ptph_pkg::ptph_hdr_t g, ptph_pkg::ptph_hdr_t e);
        checked++;
        if (g !== e)
            bad(g, e);
    endtask
    task automatic cmp_lay(logic [88:0] g, logic [88:0] e);
        checked++;
        if (g !== e)
            bad({71'h0, g}, {71'h0, e});
    endtask
    // Register write, one strobe cycle
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Register read; data stands only in the following cycle
    task automatic rd(logic [15:0] a, logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp_reg(reg_rdata, e);
    endtask
    task automatic cfg(logic [31:0] c, logic [31:0] s, logic [31:0] g, logic [31:0] n, logic b);
        ctrl = c;
        sizes = s;
        gaps = g;
        snapv = n;
        big = b;
        wr(ptph_pkg::OFF_CTRL, c);
        wr(ptph_pkg::OFF_SIZES, s);
        wr(ptph_pkg::OFF_GAPS, g);
        wr(ptph_pkg::OFF_SNAP, n);
        wr(ptph_pkg::OFF_SCRATCH, {28'h0, b, 3'h0});
    endtask
    // One request held until taken; may follow the last with no gap
    task automatic disp(ptph_pkg::ptph_req_t r);
        disp_valid <= 1'b1;
        disp_req <= r;
        do
            @(negedge clk_sys);
        while (!disp_ready);
        @(posedge clk_sys);
        hq.push_back(exp_hdr(r, tcount[23:0]));
        lq.push_back(exp_lay(r.size_code));
        tcount++;
    endtask
    // Random back-to-back requests; second one matches the snapshot value
    task automatic batch(int n);
        for (int i = 0; i < n; i++)
        begin
            rv = {$urandom, $urandom, $urandom, $urandom};
            rq = rv[113:0];
            if (rq.size_code > 4'hb)
                rq.size_code = rq.size_code - 4'h4;
            if (big)
                rq.scratch_ptr[12:0] = 13'h0;
            if (i == 1)
                rq.prim_cnt = snapv[23:0];
            disp(rq);
        end
        disp_valid <= 1'b0;
    endtask
    // Compare each payload in the cycle the shader units take it
    always @(negedge clk_sys)
    begin
        if (!reset && thr_valid && thr_ready)
        begin
            cmp_hdr(thr_hdr, hq.pop_front());
            cmp_lay({thr_ph_en, thr_ph_start, thr_len, thr_scratch_kb}, lq.pop_front());
        end
    end
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(4));
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata, disp_valid, disp_req, slow, big} = '0;
        reset = 1'b1;
        {ctrl, sizes, gaps, snapv} = {ptph_pkg::CTRL_RST, ptph_pkg::SIZES_RST, 64'h0};
        {n_fail, checked, tcount} = '0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        rd(ptph_pkg::OFF_CTRL, ptph_pkg::CTRL_RST);
        rd(ptph_pkg::OFF_SIZES, ptph_pkg::SIZES_RST);
        rd(ptph_pkg::OFF_GAPS, ptph_pkg::GAPS_RST);
        rd(ptph_pkg::OFF_SCRATCH, ptph_pkg::SCR_RST);
        rd(16'h0040, 32'h00000000);
        batch(5);
        cfg(32'h0000ff03, 32'h21312111, 32'h00302000, 32'h00000007, 1'b0);
        batch(6);
        for (int k = 0; k < 8; k++)
        begin
            cfg({16'h0, 8'($urandom), 6'h0, 2'(k)}, $urandom, $urandom & 32'h3f3f, 32'(tcount + 3), k[2]);
            slow = k[0];
            batch(12);
        end
        rd(ptph_pkg::OFF_SCRATCH, 32'h00000008);
        rd(ptph_pkg::OFF_STAT, {1'b0, 31'(tcount)});
        rq.size_code = 4'hb;
        rq.scratch_ptr = 22'h000001;
        disp(rq);
        disp_valid <= 1'b0;
        rd(ptph_pkg::OFF_STAT, {1'b1, 31'(tcount)});
        wr(ptph_pkg::OFF_STAT, 32'h80000000);
        rd(ptph_pkg::OFF_STAT, {1'b0, 31'(tcount)});
        rd(ptph_pkg::OFF_SNAP, snapv);
        rv[88:0] = exp_lay(rq.size_code);
        rd(ptph_pkg::OFF_LAY_LO, rv[48:17]);
        rd(ptph_pkg::OFF_LAY_HI, rv[80:49]);
        wait (hq.size() == 0);
        repeat (4) @(posedge clk_sys);
        end_sim();
    end
endmodule // ptph_core_test
`default_nettype wire
